// >>> design/flash_seq_regs.svh
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH
// opcodes
`define OP_QREAD      8'hEB
`define OP_QREAD_W    8'hEC
`define OP_WRAP       8'h77
`define OP_PROG       8'h02
`define OP_PROG_W     8'h12
`define OP_QPROG      8'h32
`define OP_QPROG_W    8'h34
`define OP_WIPE       8'h20
`define OP_WIPE_W     8'h21
`define OP_UNLOCK     8'h06
`define OP_ADDR4_ON   8'hB7
`define OP_ADDR4_OFF  8'hE9
`define OP_RESET      8'h99
// continuous-read field value, mode bits 5:4
`define CONT_KEEP     2'h2
// wrap bits {wrap_length_bits,w4} reset value: wrapping off
`define WRAP_RESET    3'h1
`define PAGE_BYTES    256
`define SECTOR_BYTES  4096
// timing
`define CLK_PERIOD_NS 40
`define PROG_TIME_NS  500000
`define WIPE_TIME_NS  50000000
`endif

// >>> design/flash_seq_pkg.sv
package flash_seq_pkg;
    typedef enum logic [3:0] {
        L_CMD   = 4'h0,
        L_ADDR  = 4'h1,
        L_MODE  = 4'h2,
        L_DUMMY = 4'h3,
        L_RDATA = 4'h4,
        L_WADDR = 4'h5,
        L_WDATA = 4'h6,
        L_WRAP  = 4'h7,
        L_IGN   = 4'h8
    } link_st_t;
    typedef enum logic [1:0] {
        K_NONE   = 2'h0,
        K_UNLOCK = 2'h1,
        K_PROG   = 2'h2,
        K_WIPE   = 2'h3
    } kind_t;
    typedef enum logic [1:0] {
        C_IDLE = 2'h0,
        C_PROG = 2'h1,
        C_WIPE = 2'h2,
        C_WAIT = 2'h3
    } core_st_t;
    // frame result handed from link to core at frame end
    typedef struct packed {
        kind_t       kind;
        logic        ok;
        logic [31:0] addr;
    } frame_t;
endpackage

// >>> design/quad_flash_seq.sv
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
// Behaviour
// - quad read takes address, mode, four dummies
// - read drives nibbles, address advances per byte
// - mode 10 keeps next frame opcode-free
// - other mode value needs opcode again
// - reset command not decoded during continuous read
// - w4 low wraps, wrap_length_bits pick length
// - wrapping stays inside aligned section
// - wrap setting persists until changed
// - program and erase need write latch
// - program data wraps within page
// - only last 256 bytes programmed
// - unsent page bytes stay unchanged
// - program ends on byte boundary only
// - program cycle sets busy, clears latch
// - protected page not programmed
// - quad program only with quad enable
// - erase whole sector of address
// - erase ends right after address
// - erase cycle busy, clears latch
// - protected sector not erased
// - wide-address command sets size bit
// - unlock command sets write latch
module quad_flash_seq #(
    parameter int MEM_AW      = 16,
    parameter int PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS,
    parameter int WIPE_CYCLES = `WIPE_TIME_NS / `CLK_PERIOD_NS
) (
    // core clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // serial link
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic [3:0] io_i,
    output logic      [3:0] io_o,
    output logic      [3:0] io_oe_n_o,
    // status and protection
    input  wire logic       quad_enable_bit_i,
    input  wire logic [3:0] protect_level_bits_i,
    input  wire logic       protect_top_bottom_i,
    output logic            write_in_progress_o,
    output logic            write_enable_latch_o,
    output logic            address_size_bit_o
);
    import flash_seq_pkg::*;

    logic [7:0] mem [0:(1<<MEM_AW)-1];
    logic [7:0] pbuf [0:`PAGE_BYTES-1];
    logic [`PAGE_BYTES-1:0] pvalid_q;

    // ----------------------------------------
    // link domain: synchronisers
    // ----------------------------------------
    logic lrst1_q, lrst_q, qe1_q, qe_q, busy1_q, busy_q;
    logic wip_q;
    always_ff @(posedge sclk_i)
    begin
        lrst1_q <= reset_n_i;
        lrst_q  <= lrst1_q;
        qe1_q   <= quad_enable_bit_i;
        qe_q    <= qe1_q;
        busy1_q <= wip_q;
        busy_q  <= busy1_q;
    end

    // ----------------------------------------
    // link domain: decode
    // ----------------------------------------
    link_st_t    st_q;
    logic [5:0]  cnt_q;
    logic [31:0] sh_q;
    frame_t      fr_q;
    logic        quad_q, wide_q, cont_q, ads_q, qread_q;
    logic [2:0]  wrap_q;
    logic [8:0]  bc_q;

    wire cont_go  = st_q == L_CMD && cnt_q == 6'h00 && cont_q;
    wire first_e  = st_q == L_CMD && cnt_q == 6'h00;
    wire op_end   = st_q == L_CMD && cnt_q == 6'h07;
    wire [7:0] op = {sh_q[6:0], io_i[0]};
    wire qsh = cont_go || st_q == L_ADDR || st_q == L_MODE
            || ((st_q == L_WADDR || st_q == L_WDATA) && quad_q);
    wire [31:0] sh_d = qsh ? {sh_q[27:0], io_i} : {sh_q[30:0], io_i[0]};
    wire wide_op = op == `OP_QREAD_W || op == `OP_PROG_W
                || op == `OP_QPROG_W || op == `OP_WIPE_W;
    wire wide_n  = ads_q || wide_op;
    wire [5:0] alen = wide_q ? (qsh ? 6'h08 : 6'h20) : (qsh ? 6'h06 : 6'h18);
    wire addr_end = (st_q == L_ADDR || st_q == L_WADDR) && cnt_q == alen - 6'h01;
    wire [31:0] addr_v = wide_q ? sh_d : {8'h00, sh_d[23:0]};
    wire mode_end = st_q == L_MODE && cnt_q == 6'h01;
    wire wrap_end = st_q == L_WRAP && cnt_q == 6'h1F;
    wire [5:0] blen = quad_q ? 6'h02 : 6'h08;
    wire byte_end = st_q == L_WDATA && cnt_q == blen - 6'h01;
    wire is_qprog = op == `OP_QPROG || op == `OP_QPROG_W;
    wire is_prog  = op == `OP_PROG || op == `OP_PROG_W || is_qprog;
    wire is_wipe  = op == `OP_WIPE || op == `OP_WIPE_W;
    wire is_read  = op == `OP_QREAD || op == `OP_QREAD_W;
    // busy or quad-disabled program frames are dropped at the opcode
    wire wr_ok    = !busy_q && !(is_qprog && !qe_q);
    wire [7:0] rd_byte = mem[fr_q.addr[MEM_AW-1:0]];
    // wrap section mask: 8 << length minus one
    wire wrap_on  = !wrap_q[0];
    wire [7:0] wmask = (8'h08 << wrap_q[2:1]) - 8'h01;
    wire [31:0] a_inc = fr_q.addr + 32'h1;
    wire [31:0] a_nxt = wrap_on ?
        ((fr_q.addr & ~{24'h0, wmask}) | (a_inc & {24'h0, wmask})) : a_inc;
    // next byte fetched ahead so its high nibble leaves on the advancing edge
    wire [7:0] rd_next = mem[a_nxt[MEM_AW-1:0]];
    wire [7:0] pidx = fr_q.addr[7:0] + bc_q[7:0];
    // cs high ends the frame: sclk may stop, so release lines asynchronously
    always_ff @(posedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            st_q      <= L_CMD;
            cnt_q     <= 6'h00;
            io_oe_n_o <= 4'hF;
            io_o      <= 4'h0;
        end
        else
        begin
            cnt_q <= cnt_q + 6'h01;
            case (st_q)
                L_CMD:
                begin
                    if (cont_go)
                        st_q <= L_ADDR;
                    else if (op_end)
                    begin
                        cnt_q <= 6'h00;
                        if (is_read)
                            st_q <= L_ADDR;
                        else if (op == `OP_WRAP)
                            st_q <= L_WRAP;
                        else if ((is_prog || is_wipe) && wr_ok)
                            st_q <= L_WADDR;
                        else
                            st_q <= L_IGN;
                    end
                end
                L_ADDR, L_WADDR:
                begin
                    if (addr_end)
                    begin
                        cnt_q <= 6'h00;
                        if (st_q == L_ADDR)
                            st_q <= L_MODE;
                        else
                            st_q <= (fr_q.kind == K_PROG) ? L_WDATA : L_IGN;
                    end
                end
                L_MODE:
                begin
                    if (mode_end)
                    begin
                        st_q  <= L_DUMMY;
                        cnt_q <= 6'h00;
                    end
                end
                L_DUMMY:
                begin
                    if (cnt_q == 6'h03)
                    begin
                        st_q      <= L_RDATA;
                        cnt_q     <= 6'h00;
                        io_oe_n_o <= 4'h0;
                        io_o      <= rd_byte[7:4];
                    end
                end
                L_RDATA:
                begin
                    cnt_q <= {5'h00, ~cnt_q[0]};
                    io_o  <= cnt_q[0] ? rd_next[7:4] : rd_byte[3:0];
                end
                L_WDATA:
                    if (byte_end)
                        cnt_q <= 6'h00;
                L_WRAP:
                    if (wrap_end)
                        st_q <= L_IGN;
                default:
                    cnt_q <= 6'h00;
            endcase
        end
    end
    // frame results and persistent link settings
    always_ff @(posedge sclk_i)
    begin
        if (!lrst_q)
        begin
            fr_q    <= '0;
            quad_q  <= 1'b0;
            wide_q  <= 1'b0;
            cont_q  <= 1'b0;
            ads_q   <= 1'b0;
            qread_q <= 1'b0;
            wrap_q  <= `WRAP_RESET;
            bc_q    <= 9'h000;
        end
        else
        begin
            sh_q <= sh_d;
            if (first_e)
                fr_q.ok <= 1'b0;
            if (cont_go)
            begin
                qread_q <= 1'b1;
                wide_q  <= ads_q;
                fr_q.kind <= K_NONE;
            end
            if (op_end)
            begin
                wide_q    <= wide_n;
                quad_q    <= is_qprog;
                qread_q   <= is_read;
                fr_q.kind <= (is_prog && wr_ok) ? K_PROG
                           : (is_wipe && wr_ok) ? K_WIPE
                           : (op == `OP_UNLOCK) ? K_UNLOCK : K_NONE;
                fr_q.ok   <= op == `OP_UNLOCK;
                if (op == `OP_ADDR4_ON)
                    ads_q <= 1'b1;
                if (op == `OP_ADDR4_OFF)
                    ads_q <= 1'b0;
                if (op == `OP_RESET)
                    cont_q <= 1'b0;
            end
            if (addr_end)
            begin
                fr_q.addr <= addr_v;
                fr_q.ok   <= st_q == L_WADDR && fr_q.kind == K_WIPE;
                bc_q      <= 9'h000;
            end
            if (mode_end)
                cont_q <= sh_d[5:4] == `CONT_KEEP;
            if (wrap_end)
                wrap_q <= sh_d[6:4];
            if (st_q == L_RDATA && cnt_q[0])
                fr_q.addr <= a_nxt;
            if (st_q == L_WDATA)
                fr_q.ok <= byte_end;
            if (byte_end)
                bc_q <= bc_q + 9'h001;
            if (st_q == L_IGN || (st_q == L_WRAP && wrap_end))
                fr_q.ok <= st_q == L_IGN ? 1'b0 : fr_q.ok;
        end
    end
    // page buffer: each byte lands at page offset, later bytes overwrite
    always_ff @(posedge sclk_i)
    begin
        if (!lrst_q || (addr_end && st_q == L_WADDR))
            pvalid_q <= '0;
        else if (byte_end)
            pvalid_q[pidx] <= 1'b1;
        if (byte_end)
            pbuf[pidx] <= sh_d[7:0];
    end

    // ----------------------------------------
    // core domain
    // ----------------------------------------
    logic cs1_q, cs2_q, cs3_q, ads1_q, ads2_q;
    always_ff @(posedge clk_i)
    begin
        cs1_q  <= cs_n_i;
        cs2_q  <= cs1_q;
        cs3_q  <= cs2_q;
        ads1_q <= ads_q;
        ads2_q <= ads1_q;
    end
    // link results are stable while cs is high, so the edge may sample them
    wire cs_rise = cs2_q && !cs3_q;

    core_st_t    cst_q;
    logic        wel_q;
    logic [12:0] idx_q;
    logic [31:0] tmr_q;
    logic [31:0] base_q;
    // protected span: 2^(level-1) sectors at the top or bottom
    wire [32:0] span  = (33'(`SECTOR_BYTES) << protect_level_bits_i) >> 1;
    wire [32:0] a33   = {1'b0, fr_q.addr};
    wire [32:0] msize = 33'h1 << MEM_AW;
    wire prot_hit = protect_level_bits_i != 4'h0 &&
        (protect_top_bottom_i ? a33 < span : a33 >= msize - span);
    wire go = cs_rise && !wip_q && fr_q.ok && wel_q && !prot_hit;
    wire go_prog = go && fr_q.kind == K_PROG;
    wire go_wipe = go && fr_q.kind == K_WIPE;
    wire unlock  = cs_rise && !wip_q && fr_q.ok && fr_q.kind == K_UNLOCK;

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cst_q <= C_IDLE;
            wel_q <= 1'b0;
            wip_q <= 1'b0;
            idx_q <= 13'h0000;
            tmr_q <= 32'h0;
            base_q <= 32'h0;
        end
        else
        begin
            idx_q <= idx_q + 13'h0001;
            if (tmr_q != 32'h0)
                tmr_q <= tmr_q - 32'h1;
            case (cst_q)
                C_IDLE:
                begin
                    idx_q <= 13'h0000;
                    if (go_prog || go_wipe)
                    begin
                        wip_q  <= 1'b1;
                        cst_q  <= go_prog ? C_PROG : C_WIPE;
                        tmr_q  <= 32'(go_prog ? PROG_CYCLES : WIPE_CYCLES);
                        base_q <= go_prog ? {fr_q.addr[31:8], 8'h00}
                                          : {fr_q.addr[31:12], 12'h000};
                    end
                end
                C_PROG:
                    if (idx_q == 13'h00FF)
                        cst_q <= C_WAIT;
                C_WIPE:
                    if (idx_q == 13'h0FFF)
                        cst_q <= C_WAIT;
                default:
                begin
                    if (tmr_q == 32'h3)
                        wel_q <= 1'b0;
                    if (tmr_q <= 32'h1)
                    begin
                        wip_q <= 1'b0;
                        cst_q <= C_IDLE;
                    end
                end
            endcase
            if (unlock)
                wel_q <= 1'b1;
        end
    end
    wire [MEM_AW-1:0] wa = base_q[MEM_AW-1:0] + MEM_AW'(idx_q);
    always_ff @(posedge clk_i)
    begin
        if (cst_q == C_PROG && pvalid_q[idx_q[7:0]])
            mem[wa] <= pbuf[idx_q[7:0]];
        else if (cst_q == C_WIPE)
            mem[wa] <= 8'hFF;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            write_in_progress_o  <= 1'b0;
            write_enable_latch_o <= 1'b0;
            address_size_bit_o   <= 1'b0;
        end
        else
        begin
            write_in_progress_o  <= wip_q;
            write_enable_latch_o <= wel_q;
            address_size_bit_o   <= ads2_q;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_start_needs_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(wip_q) |-> $past(wel_q) && !$past(prot_hit)) else $error("cycle started without latch");
    a_latch_gone_at_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $fell(wip_q) |-> !wel_q && $past(wel_q, 2) == 1'b0) else $error("latch still set at end");
    a_protect_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cs_rise && prot_hit && !wip_q |=> !wip_q) else $error("protected area written");
    a_unlock_sets: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        unlock |=> wel_q [*2]) else $error("unlock did not set latch");
    a_bad_end_drops: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cs_rise && !fr_q.ok && !wip_q |=> !wip_q) else $error("bad frame executed");
    a_cycle_busy: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(wip_q) |-> wip_q [*8]) else $error("busy dropped early");
    a_read_advance: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        st_q == L_RDATA && cnt_q[0] && !wrap_on |=> fr_q.addr == $past(fr_q.addr) + 32'h1)
        else $error("read address not advanced");
    a_wrap_section: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        st_q == L_RDATA && wrap_on |=> ((fr_q.addr ^ $past(fr_q.addr)) & ~{24'h0, $past(wmask)}) == 32'h0)
        else $error("wrap left section");
    a_cont_skips_op: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        cont_go |=> st_q == L_ADDR && cnt_q == 6'h01) else $error("continuous read needed opcode");
    a_quad_gate: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        op_end && is_qprog && !qe_q |=> st_q == L_IGN) else $error("quad program without enable");
    c_read: cover property (@(posedge sclk_i) disable iff (cs_n_i) st_q == L_RDATA ##2 st_q == L_RDATA);
    c_wrap_set: cover property (@(posedge sclk_i) disable iff (cs_n_i) wrap_end);
    c_prog: cover property (@(posedge clk_i) disable iff (!reset_n_i) go_prog);
    c_wipe: cover property (@(posedge clk_i) disable iff (!reset_n_i) go_wipe);
endmodule

// >>> verification/flash_host_model.sv
`timescale 1ns/100ps
// ------------------------------------
// host controller seen from the pins
// ------------------------------------
module flash_host_model #(
    parameter int HALF_NS = 80
) (
    // lane levels as seen on the wire
    input  wire logic [3:0] io_seen_i,
    // link outputs
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic      [3:0] host_io_o
);
    logic [7:0] rd_q [$];

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        host_io_o = 4'h5;
    end

    // released lanes show a changing pattern, never the last level
    task automatic tick(input logic drive, input logic [3:0] v);
        host_io_o = drive ? v : ~host_io_o;
        #(HALF_NS) sclk_o = 1'b1;
        #(HALF_NS) sclk_o = 1'b0;
    endtask

    task automatic start();
        cs_n_o = 1'b0;
        #(HALF_NS);
    endtask

    // clock stays low; select rises right after the last whole unit
    task automatic stop();
        cs_n_o = 1'b1;
        host_io_o = ~host_io_o;
        #400;
    endtask

    task automatic send_ser(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            tick(1'b1, {3'h7, v[i]});
    endtask

    task automatic send_quad(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            tick(1'b1, v[4*i +: 4]);
    endtask

    // sample each nibble just before the edge that replaces it
    task automatic read_quad(input int n);
        logic [7:0] b;
        b = 8'h00;
        rd_q.delete();
        for (int i = 0; i < 2 * n; i++)
        begin
            host_io_o = ~host_io_o;
            #(HALF_NS) b = {b[3:0], io_seen_i};
            sclk_o = 1'b1;
            #(HALF_NS) sclk_o = 1'b0;
            if (i[0])
                rd_q.push_back(b);
        end
    endtask
endmodule

// >>> verification/quad_flash_read_program_erase_tb_top.sv
`timescale 1ns/100ps
module quad_flash_read_program_erase_tb_top;
    localparam int PROG_N = 300;
    localparam int WIPE_N = 4200;

    logic       clk;
    logic       reset_n;
    logic       qe;
    logic [3:0] prot_lvl;
    logic       prot_tb;
    logic       sclk;
    logic       cs_n;
    logic [3:0] host_io;
    logic [3:0] io_dev;
    logic [3:0] oe_n;
    logic [3:0] io_line;
    logic       write_in_progress;
    logic       write_enable_latch;
    logic       address_size_bit;
    logic [7:0] shadow [0:65535];
    int         num_errors;
    int         checks_done;
    int         wrap_len;

    // each lane carries whoever enables it
    assign io_line = (oe_n & host_io) | (~oe_n & io_dev);

    quad_flash_seq #(
        .MEM_AW      (16),
        .PROG_CYCLES (PROG_N),
        .WIPE_CYCLES (WIPE_N)
    ) dut (
        .clk_i                (clk),
        .reset_n_i            (reset_n),
        .sclk_i               (sclk),
        .cs_n_i               (cs_n),
        .io_i                 (io_line),
        .io_o                 (io_dev),
        .io_oe_n_o            (oe_n),
        .quad_enable_bit_i    (qe),
        .protect_level_bits_i (prot_lvl),
        .protect_top_bottom_i (prot_tb),
        .write_in_progress_o  (write_in_progress),
        .write_enable_latch_o (write_enable_latch),
        .address_size_bit_o   (address_size_bit)
    );

    flash_host_model host (
        .io_seen_i (io_line),
        .sclk_o    (sclk),
        .cs_n_o    (cs_n),
        .host_io_o (host_io)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        checks_done++;
        if (seen !== want)
        begin
            num_errors++;
            $display("unexpected at %0t ns: %s seen %0h expected %0h", $time, what, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op);
        host.start();
        host.send_ser(op, 8);
        host.stop();
        repeat (10) @(negedge clk);
    endtask

    task automatic unlock();
        cmd(8'h06);
        check(write_enable_latch, 1'b1, "latch set");
    endtask

    task automatic busy_cycle(input int lim);
        int n;
        logic last_wel;
        n = 0;
        last_wel = 1'b1;
        while (write_in_progress !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check(write_in_progress, 1'b1, "busy start");
        n = 0;
        while (write_in_progress === 1'b1 && n < lim + 50)
        begin
            last_wel = write_enable_latch;
            @(negedge clk);
            n++;
        end
        // counting starts about seven clocks into the cycle, after the frame's tail
        check(n >= lim - 12 && n <= lim, 1'b1, "busy length");
        check(write_in_progress, 1'b0, "busy end");
        check(last_wel, 1'b0, "latch cleared before end");
    endtask

    task automatic no_busy();
        int n;
        n = 0;
        repeat (30)
        begin
            @(negedge clk);
            if (write_in_progress !== 1'b0)
                n++;
        end
        check(n, 0, "no cycle");
    endtask

    task automatic erase(input logic [23:0] a, input logic run);
        host.start();
        host.send_ser(8'h20, 8);
        host.send_ser(a, 24);
        host.stop();
        if (run)
        begin
            for (int k = 0; k < 4096; k++)
                shadow[{a[15:12], 12'(k)}] = 8'hFF;
            busy_cycle(WIPE_N);
        end
        else
            no_busy();
    endtask

    task automatic prog(input logic quad, input logic [23:0] a, input int n, input logic run);
        logic [7:0] d;
        logic [15:0] ad;
        host.start();
        host.send_ser(quad ? 8'h32 : 8'h02, 8);
        if (quad)
            host.send_quad(a, 6);
        else
            host.send_ser(a, 24);
        for (int k = 0; k < n; k++)
        begin
            d = (8'h3C + 8'(k * 17)) ^ ((k > 255) ? 8'hFF : 8'h00);
            if (quad)
                host.send_quad(d, 2);
            else
                host.send_ser(d, 8);
            ad = {a[15:8], a[7:0] + 8'(k)};
            // only the last 256 bytes of an overlong burst reach the page
            if (run && k + 256 >= n)
                shadow[ad] = shadow[ad] & d;
        end
        host.stop();
        if (run)
            busy_cycle(PROG_N);
        else
            no_busy();
    endtask

    task automatic qread(input logic op, input logic [23:0] a, input logic [7:0] m, input int n);
        logic [15:0] ad;
        host.start();
        if (op)
            host.send_ser(8'hEB, 8);
        host.send_quad(a, 6);
        host.send_quad(m, 2);
        repeat (4) host.tick(1'b0, 4'h0);
        host.read_quad(n);
        host.stop();
        for (int i = 0; i < n; i++)
        begin
            ad = a[15:0] + 16'(i);
            if (wrap_len != 0)
                ad = (a[15:0] & ~16'(wrap_len - 1)) | (ad & 16'(wrap_len - 1));
            check(host.rd_q[i], shadow[ad], "read byte");
        end
    endtask

    task automatic set_wrap(input logic [7:0] w);
        host.start();
        host.send_ser(8'h77, 8);
        host.send_ser(24'h0, 24);
        host.send_ser(w, 8);
        host.stop();
        wrap_len = w[4] ? 0 : 8 << w[6:5];
    endtask

    task automatic t_erase_program();
        erase(24'h000123, 1'b0);
        unlock();
        erase(24'h000123, 1'b1);
        unlock();
        prog(1'b0, 24'h0000FE, 4, 1'b1);
        qread(1'b1, 24'h0000FC, 8'h00, 8);
        qread(1'b1, 24'h000000, 8'h00, 4);
        unlock();
        prog(1'b0, 24'h000200, 257, 1'b1);
        qread(1'b1, 24'h0001FE, 8'h00, 6);
        $display("test erase and program done");
    endtask

    task automatic t_abort_quad();
        unlock();
        host.start();
        host.send_ser(8'h02, 8);
        host.send_ser(24'h000050, 24);
        host.send_ser(12'hA5A, 12);
        host.stop();
        no_busy();
        qread(1'b1, 24'h000050, 8'h00, 2);
        unlock();
        prog(1'b1, 24'h000040, 2, 1'b0);
        @(negedge clk) qe = 1'b1;
        repeat (10) @(negedge clk);
        unlock();
        prog(1'b1, 24'h000040, 3, 1'b1);
        qread(1'b1, 24'h00003F, 8'h00, 5);
        $display("test abort and quad done");
    endtask

    task automatic t_wrap_cont();
        for (int l = 0; l < 4; l++)
        begin
            set_wrap({1'b0, 2'(l), 5'h00});
            qread(1'b1, 24'h000205, 8'h00, wrap_len + 3);
            qread(1'b1, 24'h000206, 8'h00, 3);
        end
        set_wrap(8'h10);
        qread(1'b1, 24'h000206, 8'h00, 4);
        qread(1'b1, 24'h0000FE, 8'h20, 2);
        qread(1'b0, 24'h000200, 8'h00, 3);
        cmd(8'h99);
        unlock();
        cmd(8'hB7);
        check(address_size_bit, 1'b1, "wide address on");
        cmd(8'hE9);
        check(address_size_bit, 1'b0, "wide address off");
        $display("test wrap and continuous done");
    endtask

    task automatic t_protect();
        @(negedge clk);
        prot_lvl = 4'h1;
        prot_tb = 1'b1;
        unlock();
        erase(24'h000400, 1'b0);
        prog(1'b0, 24'h000300, 2, 1'b0);
        qread(1'b1, 24'h000300, 8'h00, 2);
        $display("test protect done");
    endtask

    initial
    begin
        #3000000;
        num_errors++;
        close_out();
    end

    initial
    begin
        reset_n = 1'b0;
        qe = 1'b0;
        prot_lvl = 4'h0;
        prot_tb = 1'b0;
        wrap_len = 0;
        num_errors = 0;
        checks_done = 0;
        // link side settings reset on the link clock, so pulse it while held
        fork
            repeat (3) host.tick(1'b1, 4'hF);
            repeat (6) @(negedge clk);
        join
        @(negedge clk) reset_n = 1'b1;
        repeat (3) host.tick(1'b1, 4'hF);
        check({oe_n, write_in_progress, write_enable_latch, address_size_bit}, 7'h78, "reset state");
        t_erase_program();
        t_abort_quad();
        t_wrap_cont();
        t_protect();
        close_out();
    end
endmodule
